// ### design/lin_frame_if.sv
// Frame-level link between the bus master end and the node decoder
`timescale 1ns/1ps
`default_nettype none
interface lin_frame_if;
  logic frame_valid;
  logic [7:0] id_byte;
  logic [3:0] data_count;
  logic [63:0] data;
  logic [7:0] checksum;

  // Master drives frames, node only listens
  modport master(
    output frame_valid,
    output id_byte,
    output data_count,
    output data,
    output checksum
  );
  modport node(
    input frame_valid,
    input id_byte,
    input data_count,
    input data,
    input checksum
  );
endinterface
`default_nettype wire

// ### design/lin_motion_command_decoder.sv
// Node end: decodes motion frames and drives the positioner
`timescale 1ns/1ps
`default_nettype none
module lin_motion_command_decoder (
  input wire logic clock,
  input wire logic rst_n,
  lin_frame_if.node link,
  input wire logic [6:0] own_address,
  input wire logic [5:0] short_position_id,
  input wire logic [5:0] position_with_params_id,
  input wire logic [5:0] decelerate_halt_id,
  input wire logic sleep_permit,
  input wire logic [10:0] secure_position,
  input wire logic [15:0] actual_position,
  input wire logic motion_active,
  input wire logic two_target_sequence,
  input wire logic thermal_shutdown,
  input wire logic undervoltage_level_three,
  output logic [15:0] target_position,
  output logic target_load,
  output logic [3:0] top_velocity,
  output logic [3:0] min_velocity,
  output logic [3:0] absolute_threshold,
  output logic [3:0] acceleration,
  output logic param_load,
  output logic decel_to_min,
  output logic sleep_active,
  output logic stopped_active,
  output logic frame_error
);
  import lin_motion_pkg::*;

  // ----------------------------------------------------------------
  // Alarm synchronisers and rising edges
  // ----------------------------------------------------------------
  logic thermal_s1;
  logic thermal_s2;
  logic thermal_q;
  logic uv_s1;
  logic uv_s2;
  logic uv_q;

  // Two flops each, then one more for the edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      thermal_s1 <= 1'b0;
      thermal_s2 <= 1'b0;
      thermal_q <= 1'b0;
      uv_s1 <= 1'b0;
      uv_s2 <= 1'b0;
      uv_q <= 1'b0;
    end else begin
      thermal_s1 <= thermal_shutdown;
      thermal_s2 <= thermal_s1;
      thermal_q <= thermal_s2;
      uv_s1 <= undervoltage_level_three;
      uv_s2 <= uv_s1;
      uv_q <= uv_s2;
    end
  end

  // Becoming active, not staying active, raises the stop
  wire thermal_rise = thermal_s2 & ~thermal_q;
  wire uv_rise = uv_s2 & ~uv_q;

  // ----------------------------------------------------------------
  // Frame checks
  // ----------------------------------------------------------------
  wire [5:0] fid = link.id_byte[5:0];
  wire id_ok = link.id_byte == id_with_parity(fid);
  wire sum_ok = link.checksum == data_checksum(link.data, link.data_count);
  // Only clean frames reach the decoders
  wire frame_good = link.frame_valid & id_ok & sum_ok;
  wire frame_bad = link.frame_valid & ~(id_ok & sum_ok);
  wire [7:0] byte1 = link.data[7:0];
  wire [7:0] byte2 = link.data[15:8];
  wire [7:0] byte3 = link.data[23:16];
  wire [7:0] byte4 = link.data[31:24];

  // ----------------------------------------------------------------
  // Command decoders
  // ----------------------------------------------------------------
  // Sleep: fixed identifier and exact byte pattern
  wire sleep_fill_ok = link.data[DATA_W-1:8] == {7{SLEEP_FILL}};
  wire is_sleep = frame_good & (link.id_byte == SLEEP_ID_BYTE) &
                  (link.data_count == LEN_8) & (byte1 == SLEEP_FIRST) &
                  sleep_fill_ok;

  // Param frame on this node's own identifier
  wire is_param = frame_good & (fid == position_with_params_id) &
                  (link.data_count == LEN_4);

  // Stop: command flag and code, then broadcast or own address
  wire stop_cmd_ok = byte1 == {1'b1, SOFT_STOP_CODE};
  wire stop_for_us = ~byte2[BROAD_BIT] |
                     (byte2[6:0] == own_address);
  wire is_stop_frame = frame_good & (fid == decelerate_halt_id) &
                       (link.data_count == LEN_2) & stop_cmd_ok &
                       stop_for_us;

  // Any stop source, dropped while a two-target run is on
  wire stop_req = (is_stop_frame | thermal_rise | uv_rise) &
                  ~two_target_sequence;

  // Short frame: scan the four slots for our low address bits
  logic short_hit;
  logic [10:0] short_raw;
  always_comb begin
    short_hit = 1'b0;
    short_raw = 11'h000;
    for (int k = 0; k < SLOTS; k++) begin
      if (link.data[SLOT_BITS*k + SLOT_MARK_BIT] &&
          link.data[SLOT_BITS*k +: 4] == own_address[3:0]) begin
        short_hit = 1'b1;
        short_raw = {link.data[SLOT_BITS*k + SLOT_HI_MSB -: 3],
                     link.data[SLOT_BITS*k + SLOT_LO_LSB +: 8]};
      end
    end
  end

  wire is_short = frame_good & (fid == short_position_id) &
                  (link.data_count == LEN_8) & short_hit;

  // Short values are 32-step units: scale onto the full range
  wire [15:0] short_full = {short_raw, {SHORT_SHIFT{1'b0}}};
  wire [15:0] secure_full = {secure_position, {SHORT_SHIFT{1'b0}}};
  wire secure_usable = secure_position != SECURE_DISABLE;
  wire [15:0] param_pos = {byte1, byte2};
  wire motion_state_t rest_state =
    sleep_permit ? MS_SLEEP : MS_STOPPED;

  // ----------------------------------------------------------------
  // Motion state machine
  // ----------------------------------------------------------------
  motion_state_t state;
  motion_state_t next_state;
  logic sleep_after;
  logic next_sleep_after;
  logic [15:0] next_target;
  logic next_load;

  always_comb begin
    next_state = state;
    next_sleep_after = sleep_after;
    next_target = target_position;
    next_load = 1'b0;
    case (state)
      MS_RUN, MS_STOPPED: begin
        if (is_sleep) begin
          if (!motion_active) begin
            next_state = rest_state;
          end else if (secure_usable) begin
            next_target = secure_full;
            next_load = 1'b1;
            next_state = MS_PARK;
          end else begin
            next_state = MS_HALT;
            next_sleep_after = 1'b1;
          end
        end else if (stop_req && motion_active) begin
          next_state = MS_HALT;
          next_sleep_after = 1'b0;
        end else if (is_param) begin
          next_target = param_pos;
          next_load = 1'b1;
          next_state = MS_RUN;
        end else if (is_short) begin
          next_target = short_full;
          next_load = 1'b1;
          next_state = MS_RUN;
        end
      end
      MS_HALT: begin
        if (is_sleep) begin
          next_sleep_after = 1'b1;
        end
        if (!motion_active) begin
          next_target = actual_position;
          next_load = 1'b1;
          next_state = (sleep_after | is_sleep) ? rest_state : MS_RUN;
        end
      end
      MS_PARK: begin
        if (stop_req) begin
          next_state = MS_HALT;
          next_sleep_after = 1'b1;
        end else if (!motion_active) begin
          next_state = rest_state;
        end
      end
      MS_SLEEP: begin
        // Any clean frame other than sleep wakes the node, the frame itself is dropped
        if (frame_good && !is_sleep) begin
          next_state = MS_RUN;
        end
      end
      default: begin
        next_state = MS_RUN;
      end
    endcase
  end

  // State and target registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= MS_RUN;
      sleep_after <= 1'b0;
      target_position <= POS_RESET;
      target_load <= 1'b0;
    end else begin
      state <= next_state;
      sleep_after <= next_sleep_after;
      target_position <= next_target;
      target_load <= next_load;
    end
  end

  // Registered views of the state and of frame errors for the driver
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      decel_to_min <= 1'b0;
      sleep_active <= 1'b0;
      stopped_active <= 1'b0;
      frame_error <= 1'b0;
    end else begin
      decel_to_min <= next_state == MS_HALT;
      sleep_active <= next_state == MS_SLEEP;
      stopped_active <= next_state == MS_STOPPED;
      frame_error <= frame_bad;
    end
  end

  // ----------------------------------------------------------------
  // Motion parameters
  // ----------------------------------------------------------------
  wire param_take = is_param & ((state == MS_RUN) | (state == MS_STOPPED)) &
                    ~is_sleep & ~(stop_req & motion_active);

  // Velocity nibbles, threshold above acceleration
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      top_velocity <= NIBBLE_RESET;
      min_velocity <= NIBBLE_RESET;
      absolute_threshold <= NIBBLE_RESET;
      acceleration <= NIBBLE_RESET;
      param_load <= 1'b0;
    end else begin
      param_load <= param_take;
      if (param_take) begin
        top_velocity <= byte3[7:4];
        min_velocity <= byte3[3:0];
        absolute_threshold <= byte4[7:4];
        acceleration <= byte4[3:0];
      end
    end
  end
endmodule
`default_nettype wire

// ### design/lin_motion_master.sv
// Master end: builds checked motion frames from user commands
`timescale 1ns/1ps
`default_nettype none
module lin_motion_master (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire lin_motion_pkg::frame_kind_t cmd_kind,
  input wire logic [5:0] cmd_id,
  input wire logic [63:0] cmd_data,
  input wire logic cmd_corrupt,
  lin_frame_if.master link
);
  import lin_motion_pkg::*;

  // ----------------------------------------------------------------
  // Frame assembly
  // ----------------------------------------------------------------
  logic [3:0] len;
  logic [63:0] body;
  logic [7:0] idb;

  // Length, fixed bytes and identifier per command kind
  always_comb begin
    len = LEN_8;
    body = cmd_data;
    idb = id_with_parity(cmd_id);
    case (cmd_kind)
      KIND_SHORT: begin
        len = LEN_8;
      end
      KIND_PARAM: begin
        len = LEN_4;
      end
      KIND_SLEEP: begin
        len = LEN_8;
        body = {{7{SLEEP_FILL}}, SLEEP_FIRST};
        idb = SLEEP_ID_BYTE;
      end
      KIND_STOP: begin
        len = LEN_2;
        body[7:0] = {1'b1, SOFT_STOP_CODE};
      end
      default: begin
        len = LEN_8;
      end
    endcase
    // Bytes past the length go out as zero
    for (int i = 0; i < DATA_BYTES; i++) begin
      if (i >= int'(len)) begin
        body[8*i +: 8] = 8'h00;
      end
    end
  end

  wire [7:0] sum = data_checksum(body, len);
  wire [7:0] sum_sent = cmd_corrupt ? ~sum : sum;

  // ----------------------------------------------------------------
  // Link registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link.frame_valid <= 1'b0;
      link.id_byte <= 8'h00;
      link.data_count <= 4'h0;
      link.data <= 64'h0000000000000000;
      link.checksum <= 8'h00;
    end else begin
      link.frame_valid <= cmd_valid;
      if (cmd_valid) begin
        link.id_byte <= idb;
        link.data_count <= len;
        link.data <= body;
        link.checksum <= sum_sent;
      end
    end
  end

endmodule
`default_nettype wire

// ### design/lin_motion_pkg.sv
// Shared constants, types and frame helpers for the LIN motion decoder
package lin_motion_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int DATA_BYTES = 8;
  localparam int DATA_W = 64;
  localparam logic [3:0] LEN_2 = 4'h2;
  localparam logic [3:0] LEN_4 = 4'h4;
  localparam logic [3:0] LEN_8 = 4'h8;
  localparam logic [7:0] SLEEP_ID_BYTE = 8'h3c;
  localparam logic [7:0] SLEEP_FIRST = 8'h00;
  localparam logic [7:0] SLEEP_FILL = 8'hff;
  localparam logic [6:0] SOFT_STOP_CODE = 7'h0f;
  localparam int CMD_FLAG_BIT = 7;
  localparam int BROAD_BIT = 7;

  // ----------------------------------------------------------------
  // Short position slots and position formats
  // ----------------------------------------------------------------
  localparam int SLOTS = 4;
  localparam int SLOT_BITS = 16;
  localparam int SLOT_MARK_BIT = 4;
  localparam int SLOT_HI_MSB = 7;
  localparam int SLOT_LO_LSB = 8;
  localparam int SHORT_W = 11;
  localparam int SHORT_SHIFT = 5;
  localparam int POS_W = 16;
  localparam logic [10:0] SECURE_DISABLE = 11'h400;
  localparam logic [15:0] POS_RESET = 16'h0000;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_SHORT = 2'b00,
    KIND_PARAM = 2'b01,
    KIND_SLEEP = 2'b10,
    KIND_STOP = 2'b11
  } frame_kind_t;

  typedef enum logic [2:0] {
    MS_RUN = 3'b000,
    MS_HALT = 3'b001,
    MS_PARK = 3'b010,
    MS_SLEEP = 3'b011,
    MS_STOPPED = 3'b100
  } motion_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Identifier with its two parity bits on top
  function automatic logic [7:0] id_with_parity(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0, id};
  endfunction

  // Inverted carry-folded sum over the first n data bytes
  function automatic logic [7:0] data_checksum(input logic [63:0] d,
                                               input logic [3:0] n);
    logic [8:0] s;
    s = 9'h000;
    for (int i = 0; i < DATA_BYTES; i++) begin
      if (i < int'(n)) begin
        s = {1'b0, s[7:0]} + {8'h00, s[8]} + {1'b0, d[8*i +: 8]};
      end
    end
    s = {1'b0, s[7:0]} + {8'h00, s[8]};
    return ~s[7:0];
  endfunction

endpackage

// ### tb/lin_motion_asserts.sv
// Checks on the frame link between the master and node ends
`timescale 1ns/1ps
`default_nettype none
module lin_motion_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic frame_valid,
  input wire logic [7:0] id_byte,
  input wire logic [3:0] data_count,
  input wire logic [63:0] data,
  input wire logic [7:0] checksum
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Inverted folded sum over the bytes in use
  function automatic logic [7:0] fold(input logic [63:0] d,
                                      input logic [3:0] n);
    logic [8:0] s;
    s = 9'h000;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(n)) begin
        s = {1'b0, s[7:0]} + {8'h00, s[8]} + {1'b0, d[8*i +: 8]};
      end
    end
    s = {1'b0, s[7:0]} + {8'h00, s[8]};
    return ~s[7:0];
  endfunction

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Wire rules
  // ----------------------------------------------------------------
  length_legal_a: assert property (
    frame_valid |-> data_count inside {4'h2, 4'h4, 4'h8})
    else $error("frame length not 2, 4 or 8");
  id_parity_a: assert property (
    frame_valid |-> id_byte[6] == ^{id_byte[0], id_byte[1], id_byte[2],
      id_byte[4]} && id_byte[7] == ~^{id_byte[1], id_byte[3], id_byte[4],
      id_byte[5]})
    else $error("identifier parity wrong");
  checksum_form_a: assert property (
    frame_valid |-> checksum == fold(data, data_count)
      || checksum == ~fold(data, data_count))
    else $error("checksum not over used bytes");
  sleep_pattern_a: assert property (
    frame_valid && id_byte == 8'h3c |->
      data_count == 4'h8 && data == 64'hffffffffffffff00)
    else $error("sleep frame pattern wrong");
  stop_command_a: assert property (
    frame_valid && data_count == 4'h2 |-> data[7:0] == 8'h8f)
    else $error("stop command byte wrong");
  stop_unused_a: assert property (
    frame_valid && data_count == 4'h2 |-> data[63:16] == 48'h0)
    else $error("stop frame carries extra bytes");
  param_unused_a: assert property (
    frame_valid && data_count == 4'h4 |-> data[63:32] == 32'h0)
    else $error("param frame carries extra bytes");
  frame_held_a: assert property (
    !frame_valid |-> $stable(id_byte) && $stable(data)
      && $stable(data_count) && $stable(checksum))
    else $error("frame fields moved between frames");

  // Main scenarios
  sleep_seen_c: cover property (frame_valid && id_byte == 8'h3c);
  stop_seen_c: cover property (frame_valid && data_count == 4'h2);
  param_seen_c: cover property (frame_valid && data_count == 4'h4);
endmodule
`default_nettype wire

// ### tb/lin_motion_command_decoder_bench.sv
// Bench joining the master and node ends over the frame link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin got = (a); checks_done++; if (got !== (b)) begin \
  fails++; $display("ERROR %0t: got %h expected %h", $time, got, b); end end
module lin_motion_command_decoder_bench;
  import lin_motion_pkg::*;
  logic clock, rst_n, cmd_valid, cmd_corrupt, sleep_permit, motion_active;
  logic two_target_sequence, thermal_shutdown, undervoltage_level_three;
  logic target_load, param_load, decel_to_min, sleep_active, stopped_active;
  logic frame_error, pd, ps, pt;
  frame_kind_t cmd_kind;
  logic [5:0] cmd_id, short_position_id, position_with_params_id;
  logic [5:0] decelerate_halt_id;
  logic [63:0] cmd_data;
  logic [6:0] own_address;
  logic [10:0] secure_position;
  logic [15:0] actual_position, target_position, params;
  logic [3:0] top_velocity, min_velocity, absolute_threshold, acceleration;
  logic [19:0] notes [$];
  logic [19:0] got;
  int fails, checks_done;

  lin_frame_if lin_frame_if_inst ();
  lin_motion_master lin_motion_master_inst (.clock(clock), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_id(cmd_id),
    .cmd_data(cmd_data), .cmd_corrupt(cmd_corrupt),
    .link(lin_frame_if_inst));
  lin_motion_command_decoder lin_motion_command_decoder_inst (
    .clock(clock), .rst_n(rst_n), .link(lin_frame_if_inst),
    .own_address(own_address), .short_position_id(short_position_id),
    .position_with_params_id(position_with_params_id),
    .decelerate_halt_id(decelerate_halt_id), .sleep_permit(sleep_permit),
    .secure_position(secure_position), .actual_position(actual_position),
    .motion_active(motion_active), .two_target_sequence(two_target_sequence),
    .thermal_shutdown(thermal_shutdown),
    .undervoltage_level_three(undervoltage_level_three),
    .target_position(target_position), .target_load(target_load),
    .top_velocity(top_velocity), .min_velocity(min_velocity),
    .absolute_threshold(absolute_threshold), .acceleration(acceleration),
    .param_load(param_load), .decel_to_min(decel_to_min),
    .sleep_active(sleep_active), .stopped_active(stopped_active),
    .frame_error(frame_error));
  lin_motion_asserts lin_motion_asserts_inst (.clock(clock), .rst_n(rst_n),
    .frame_valid(lin_frame_if_inst.frame_valid),
    .id_byte(lin_frame_if_inst.id_byte),
    .data_count(lin_frame_if_inst.data_count),
    .data(lin_frame_if_inst.data), .checksum(lin_frame_if_inst.checksum));

  assign params = {top_velocity, min_velocity, absolute_threshold,
    acceleration};

  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [19:0] take();
    if (notes.size() == 0) return 20'hfffff;
    return notes.pop_front();
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One command, one cycle of cmd_valid
  task automatic send(input frame_kind_t k, input logic [5:0] id,
                      input logic [63:0] d, input logic bad);
    @(posedge clock) #1;
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_id = id;
    cmd_data = d;
    cmd_corrupt = bad;
    @(posedge clock) #1;
    cmd_valid = 1'b0;
  endtask

  // Bounded wait until every note is taken
  task automatic drain(input string name);
    for (int i = 0; i < 50 && notes.size() > 0; i++) @(posedge clock);
    repeat (3) @(posedge clock);
    #1;
    if (notes.size() != 0) begin
      fails++;
      $display("ERROR %0t: result missing in %s", $time, name);
      give_verdict();
    end
    $display("test %s done", name);
  endtask

  // Each result seen on the node takes the oldest note
  always @(negedge clock) begin
    if (rst_n) begin
      if (target_load)
        `CHK(take(), {4'h1, target_position})
      if (param_load)
        `CHK(take(), {4'h2, params})
      if (frame_error)
        `CHK(take(), {4'h3, 16'h0})
      if (decel_to_min != pd)
        `CHK(take(), {4'h6, 15'h0, decel_to_min})
      if (sleep_active != ps)
        `CHK(take(), {4'h4, 15'h0, sleep_active})
      if (stopped_active != pt)
        `CHK(take(), {4'h5, 15'h0, stopped_active})
    end
    pd = decel_to_min;
    ps = sleep_active;
    pt = stopped_active;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [10:0] p [4];
    logic [63:0] d;
    logic [15:0] a;
    {rst_n, cmd_valid, cmd_corrupt, motion_active} = '0;
    {two_target_sequence, thermal_shutdown, undervoltage_level_three} = '0;
    {cmd_id, cmd_data, secure_position, actual_position} = '0;
    cmd_kind = KIND_SHORT;
    sleep_permit = 1'b1;
    own_address = 7'h25;
    short_position_id = 6'h31;
    position_with_params_id = 6'h12;
    decelerate_halt_id = 6'h05;
    void'($urandom(72167));
    repeat (4) @(posedge clock);
    #1 rst_n = 1'b1;
    // Short frame: slots 1 and 3 match, the last wins
    d = '0;
    for (int k = 0; k < 4; k++) begin
      p[k] = 11'($urandom);
      d[16*k +: 16] = {p[k][7:0], p[k][10:8], 1'b1, (k % 2) ? 4'h5 : 4'h9};
    end
    notes.push_back({4'h1, p[3], 5'h00});
    send(KIND_SHORT, 6'h31, d, 1'b0);
    drain("short");
    notes.push_back({4'h3, 16'h0});
    send(KIND_SHORT, 6'h31, d, 1'b1);
    drain("corrupt");
    // Param frame, then one under a wrong identifier
    d = {32'h0, 32'($urandom)};
    notes.push_back({4'h1, d[7:0], d[15:8]});
    notes.push_back({4'h2, d[23:16], d[31:24]});
    send(KIND_PARAM, 6'h12, d, 1'b0);
    send(KIND_PARAM, 6'h05, d, 1'b0);
    drain("param");
    // Stops: addressed, broadcast, during sequence, other node, alarms
    for (int i = 0; i < 6; i++) begin
      motion_active = 1'b1;
      two_target_sequence = (i == 2);
      a = 16'($urandom);
      if (i != 2 && i != 3) notes.push_back({4'h6, 16'h1});
      if (i < 4) begin
        send(KIND_STOP, 6'h05, {48'h0, (i == 1) ? 8'h11 :
          (i == 3) ? 8'h91 : 8'ha5, 8'h00}, 1'b0);
      end else begin
        thermal_shutdown = (i == 4);
        undervoltage_level_three = (i == 5);
      end
      drain("stop");
      actual_position = a;
      motion_active = 1'b0;
      {two_target_sequence, thermal_shutdown, undervoltage_level_three} = '0;
      if (i != 2 && i != 3) begin
        notes.push_back({4'h1, a});
        notes.push_back({4'h6, 16'h0});
      end
      drain("halt");
    end
    // Sleep in motion with a usable secure position
    secure_position = {1'b0, 10'($urandom)};
    motion_active = 1'b1;
    notes.push_back({4'h1, secure_position, 5'h00});
    send(KIND_SLEEP, 6'h00, 64'h0, 1'b0);
    drain("sleep");
    motion_active = 1'b0;
    notes.push_back({4'h4, 16'h1});
    drain("park");
    // Wake: sleep flag drops, the frame itself is dropped
    notes.push_back({4'h4, 16'h0});
    send(KIND_PARAM, 6'h12, d, 1'b0);
    drain("wake");
    // Sleep in motion with the disable code and no permit
    sleep_permit = 1'b0;
    secure_position = 11'h400;
    motion_active = 1'b1;
    a = 16'($urandom);
    notes.push_back({4'h6, 16'h1});
    send(KIND_SLEEP, 6'h00, 64'h0, 1'b0);
    drain("sleep halt");
    actual_position = a;
    motion_active = 1'b0;
    notes.push_back({4'h1, a});
    notes.push_back({4'h6, 16'h0});
    notes.push_back({4'h5, 16'h1});
    drain("stopped");
    give_verdict();
  end
endmodule
`default_nettype wire
